// ---- rtl/cis_pkg.sv ----
package cis_pkg;
  // interrupt sources and their kind (1 = level-type, no flag)
  localparam int NSRC = 4;
  localparam logic [3:0] LEVEL_MASK = 4'h8;
  // memory geometry
  localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h04ff;
  localparam logic [12:0] BOOT_START = 13'h1c00;
  localparam logic [12:0] RESET_VEC_OFS = 13'h0000;
  localparam logic [12:0] VEC_STEP = 13'h0002;
  // sequence lengths in cycles
  localparam logic [2:0] ENTRY_CYC = 3'h4;
  localparam logic [2:0] EXIT_CYC = 3'h4;
  localparam logic [2:0] WAKE_CYC = 3'h4;
  // i/o register addresses
  localparam logic [5:0] IO_SPL = 6'h10;
  localparam logic [5:0] IO_SPH = 6'h11;
  localparam logic [5:0] IO_FLAGS = 6'h12;
  localparam logic [5:0] IO_CTRL = 6'h13;
  localparam logic [5:0] IO_IFLAG = 6'h14;
  // field positions and reset values
  localparam int GIE_BIT = 7;
  localparam int RELOC_BIT = 1;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAKE = 4'h2,
    ST_ENTRY = 4'h4,
    ST_EXIT = 4'h8
  } cis_fsm_t;

  // instruction class retiring at a boundary
  typedef struct packed {
    logic push;
    logic pop;
    logic call;
    logic ret;
    logic interrupt_exit_instr;
    logic sei;
    logic cli;
  } cis_op_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } cis_io_t;

  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic post_inc;
    logic pre_dec;
    logic [5:0] disp;
    logic [7:0] wdata;
  } cis_ptr_cmd_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cis_mem_t;
endpackage : cis_pkg

// ---- rtl/cis_ptr.sv ----
`timescale 1ns/10ps
module cis_ptr
  import cis_pkg::*;
(
  input wire logic sys_clk_in, // core clock
  input wire logic rst_in, // async reset, high
  input cis_pkg::cis_ptr_cmd_t cmd_in, // byte write and addressing mode
  output logic [15:0] val_out, // pointer pair value
  output logic [15:0] addr_out // effective data address
);
  typedef struct packed {
    logic [15:0] val;
    logic [15:0] addr;
  } cis_ptr_st_t;
  cis_ptr_st_t s_q, s_d;

  // one pair of general registers acting as a pointer
  always_comb begin
    s_d = s_q;
    if (cmd_in.wr_lo) begin
      s_d.val[7:0] = cmd_in.wdata;
    end
    if (cmd_in.wr_hi) begin
      s_d.val[15:8] = cmd_in.wdata;
    end
    if (cmd_in.pre_dec) begin // RULE1
      s_d.val = s_q.val - 16'h0001;
      s_d.addr = s_q.val - 16'h0001;
    end else if (cmd_in.post_inc) begin // RULE1
      s_d.val = s_q.val + 16'h0001;
      s_d.addr = s_q.val;
    end else begin // RULE1
      s_d.addr = s_q.val + {10'h000, cmd_in.disp};
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign val_out = s_q.val;
  assign addr_out = s_q.addr;

  chk_ptr_postinc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cmd_in.post_inc && !cmd_in.pre_dec && !cmd_in.wr_lo && !cmd_in.wr_hi
    |=> val_out == $past(val_out) + 16'h0001) // RULE1
    else $error("pointer post increment wrong");
endmodule : cis_ptr

// ---- rtl/cis_core.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: registers 26 to 31 form three pointers
// RULE2: stack grows down, byte push/pop one
// RULE3: call or return moves pointer by two
// RULE4: stack pointer two bytes, reset top
// RULE5: software sets stack pointer before use
// RULE6: undivided clock, one-cycle register operations
// RULE7: take only with both enables set
// RULE8: lock bits suppress interrupts by section
// RULE9: low vectors, lower address higher priority
// RULE10: relocate bit and fuse move vectors
// RULE11: entry clears global enable, exit sets
// RULE12: vectoring or writing one clears flag
// RULE13: disabled flag event stays pending
// RULE14: level source requests only while present
// RULE15: one instruction after exit before next
// RULE16: flags register never saved by hardware
// RULE17: disable instruction blocks same-cycle interrupts
// RULE18: instruction after enable runs first
// RULE19: four-cycle entry pushing the counter
// RULE20: multi-cycle finishes; wake adds four
// RULE21: four-cycle exit pops counter, sets enable
// RULE22: lowest pending vector wins, others wait
module cis_core
  import cis_pkg::*;
(
  input wire logic sys_clk_in, // core clock, 50 MHz
  input wire logic rst_in, // async reset, high
  input wire logic instr_done_in, // instruction boundary pulse
  input cis_pkg::cis_op_t op_in, // class of retiring instruction
  input wire logic asleep_in, // core is sleeping
  input wire logic [12:0] pc_in, // return address
  input cis_pkg::cis_io_t io_in, // i/o register write
  input wire logic [5:0] io_raddr_in, // i/o register read address
  input wire logic [6:0] alu_flags_in, // alu result flags
  input wire logic alu_we_in, // alu flag update
  input wire logic [3:0] irq_cond_in, // source conditions
  input wire logic [3:0] irq_en_in, // individual enables
  input wire logic boot_reset_vector_fuse, // reset vector in boot
  input wire logic boot_lock_app_bits, // application lock
  input wire logic boot_lock_boot_bits, // boot lock
  input wire logic [7:0] mem_rdata_in, // stack read data
  input cis_pkg::cis_ptr_cmd_t [2:0] ptr_cmd_in, // x, y, z commands
  output logic [7:0] io_rdata_out, // i/o read data
  output logic [15:0] sp_out, // stack pointer
  output logic [7:0] core_flags_reg, // flags register
  output logic [3:0] irq_flag_out, // pending flags
  output cis_pkg::cis_mem_t mem_out, // stack memory access
  output logic vec_valid_out, // jump to vector pulse
  output logic [12:0] vec_addr_out, // vector address
  output logic pc_load_out, // return address valid pulse
  output logic [12:0] pc_ret_out, // popped return address
  output logic [12:0] reset_vec_out, // reset vector address
  output logic busy_out, // sequencer holds pipeline
  output logic [15:0] ptr_val_out [3], // x, y, z values
  output logic [15:0] ptr_addr_out [3] // x, y, z addresses
);
  typedef struct packed {
    cis_fsm_t fsm;
    logic [2:0] cnt;
    logic [15:0] sp;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic [3:0] iflag;
    logic [1:0] sel;
    logic [12:0] ret_pc;
    cis_mem_t mem;
    logic vec_valid;
    logic [12:0] vec_addr;
    logic pc_load;
    logic [7:0] rdata;
    logic [12:0] rst_vec;
  } cis_st_t;
  cis_st_t s_q, s_d;

  logic [3:0] req;
  logic [3:0] live;
  logic any_live;
  logic [1:0] win;
  logic gie_eff;
  logic in_boot;
  logic suppress;
  logic take;
  logic [12:0] vbase;

  // requests: flags for edge sources, the raw condition for level ones
  always_comb begin
    req = (s_q.iflag & ~LEVEL_MASK) | (irq_cond_in & LEVEL_MASK); // RULE14
    live = req & irq_en_in; // RULE7
  end

  // lowest index is the lowest vector, so it wins
  always_comb begin
    win = 2'h0;
    any_live = |live;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        win = 2'(i); // RULE22 RULE9
      end
    end
  end

  // a disable in this very cycle already masks the take
  always_comb begin
    gie_eff = s_q.flags[GIE_BIT];
    if (instr_done_in && op_in.cli) begin
      gie_eff = 1'b0; // RULE17
    end
    if (io_in.we && io_in.addr == IO_FLAGS && !io_in.data[GIE_BIT]) begin
      gie_eff = 1'b0; // RULE17
    end
  end

  // lock bits guard the section the counter is in, only while the vectors sit in the other section
  always_comb begin
    in_boot = pc_in >= BOOT_START;
    suppress = (boot_lock_app_bits && !in_boot && s_q.ctrl[RELOC_BIT]) ||
      (boot_lock_boot_bits && in_boot && !s_q.ctrl[RELOC_BIT]); // RULE8
    vbase = s_q.ctrl[RELOC_BIT] ? BOOT_START : RESET_VEC_OFS; // RULE10
  end

  // only at a finished instruction, or from sleep
  assign take = s_q.fsm == ST_IDLE && any_live && gie_eff && !suppress &&
    ((instr_done_in && !op_in.interrupt_exit_instr) || asleep_in); // RULE7 RULE15 RULE20

  always_comb begin
    s_d = s_q;
    s_d.mem.we = 1'b0;
    s_d.mem.re = 1'b0;
    s_d.vec_valid = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.rst_vec = boot_reset_vector_fuse ? BOOT_START : RESET_VEC_OFS; // RULE10
    // flag sets beat software clears in the same cycle
    if (io_in.we && io_in.addr == IO_IFLAG) begin
      s_d.iflag = s_q.iflag & ~io_in.data[3:0]; // RULE12
    end
    if (alu_we_in) begin
      s_d.flags[6:0] = alu_flags_in; // RULE6
    end
    if (io_in.we) begin
      case (io_in.addr)
        IO_SPL: s_d.sp[7:0] = io_in.data; // RULE4
        IO_SPH: s_d.sp[15:8] = io_in.data; // RULE4
        IO_FLAGS: s_d.flags = io_in.data; // RULE11
        IO_CTRL: s_d.ctrl = io_in.data; // RULE10
        default: ;
      endcase
    end
    // stack moves of the running program
    if (instr_done_in && s_q.fsm == ST_IDLE) begin
      if (op_in.push) begin
        s_d.sp = s_q.sp - 16'h0001; // RULE2
      end else if (op_in.pop) begin
        s_d.sp = s_q.sp + 16'h0001; // RULE2
      end else if (op_in.call) begin
        s_d.sp = s_q.sp - 16'h0002; // RULE3
      end else if (op_in.ret) begin
        s_d.sp = s_q.sp + 16'h0002; // RULE3
      end
      if (op_in.sei) begin
        s_d.flags[GIE_BIT] = 1'b1; // RULE18
      end
      if (op_in.cli) begin
        s_d.flags[GIE_BIT] = 1'b0; // RULE17
      end
    end
    case (s_q.fsm)
      ST_IDLE: begin
        if (take) begin
          s_d.sel = win;
          s_d.ret_pc = pc_in;
          s_d.flags[GIE_BIT] = 1'b0; // RULE11
          s_d.iflag[win] = 1'b0; // RULE12
          s_d.cnt = 3'h0;
          s_d.fsm = asleep_in ? ST_WAKE : ST_ENTRY; // RULE20
        end else if (instr_done_in && op_in.interrupt_exit_instr) begin
          s_d.cnt = 3'h0;
          s_d.fsm = ST_EXIT;
        end
      end
      ST_WAKE: begin
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt == WAKE_CYC - 3'h1) begin
          s_d.cnt = 3'h0;
          s_d.fsm = ST_ENTRY; // RULE20
        end
      end
      ST_ENTRY: begin
        // low byte first, then high; flags are not stacked
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt < 3'h2) begin
          s_d.mem.we = 1'b1; // RULE19 RULE16
          s_d.mem.addr = s_q.sp;
          s_d.mem.wdata = (s_q.cnt == 3'h0) ? s_q.ret_pc[7:0] :
            {3'h0, s_q.ret_pc[12:8]};
          s_d.sp = s_q.sp - 16'h0001; // RULE3
        end
        if (s_q.cnt == ENTRY_CYC - 3'h1) begin
          s_d.vec_valid = 1'b1; // RULE19
          s_d.vec_addr = vbase + VEC_STEP * (13'(s_q.sel) + 13'h0001); // RULE9
          s_d.fsm = ST_IDLE;
        end
      end
      ST_EXIT: begin
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt < 3'h2) begin
          s_d.mem.re = 1'b1; // RULE21
          s_d.mem.addr = s_q.sp + 16'h0001;
          s_d.sp = s_q.sp + 16'h0001; // RULE21
        end
        // read data trails the strobe by one cycle: high byte, then low
        if (s_q.cnt == 3'h2) begin
          s_d.ret_pc[12:8] = mem_rdata_in[4:0]; // RULE21
        end
        if (s_q.cnt == 3'h3) begin
          s_d.ret_pc[7:0] = mem_rdata_in; // RULE21
        end
        if (s_q.cnt == EXIT_CYC - 3'h1) begin
          s_d.flags[GIE_BIT] = 1'b1; // RULE21 RULE11
          s_d.pc_load = 1'b1;
          s_d.fsm = ST_IDLE; // RULE15
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase
    // hardware events always land, even on a clear
    s_d.iflag = s_d.iflag | (irq_cond_in & ~LEVEL_MASK); // RULE13
    // read-back mux
    case (io_raddr_in)
      IO_SPL: s_d.rdata = s_q.sp[7:0]; // RULE4
      IO_SPH: s_d.rdata = s_q.sp[15:8]; // RULE4
      IO_FLAGS: s_d.rdata = s_q.flags;
      IO_CTRL: s_d.rdata = s_q.ctrl;
      IO_IFLAG: s_d.rdata = {4'h0, s_q.iflag};
      default: s_d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.fsm <= ST_IDLE;
      s_q.sp <= TOP_OF_DATA_MEMORY; // RULE4
      s_q.flags <= FLAGS_RST;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign io_rdata_out = s_q.rdata;
  assign sp_out = s_q.sp;
  assign core_flags_reg = s_q.flags;
  assign irq_flag_out = s_q.iflag;
  assign mem_out = s_q.mem;
  assign vec_valid_out = s_q.vec_valid;
  assign vec_addr_out = s_q.vec_addr;
  assign pc_load_out = s_q.pc_load;
  assign pc_ret_out = s_q.ret_pc;
  assign reset_vec_out = s_q.rst_vec;
  assign busy_out = s_q.fsm != ST_IDLE;

  // the three pointer pairs
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    cis_ptr u_ptr (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .cmd_in(ptr_cmd_in[g]),
      .val_out(ptr_val_out[g]),
      .addr_out(ptr_addr_out[g])
    );
  end

  // checks
  sequence s_entry_start;
    s_q.fsm == ST_IDLE && s_d.fsm == ST_ENTRY;
  endsequence

  sequence s_exit_start;
    s_q.fsm == ST_IDLE && s_d.fsm == ST_EXIT;
  endsequence

  chk_entry_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_entry_start |=> !vec_valid_out [*4] ##1 vec_valid_out) // RULE19
    else $error("entry did not take four cycles");
  chk_entry_sp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_entry_start |-> ##5 sp_out == $past(sp_out, 5) - 16'h0002) // RULE3
    else $error("entry stack move not two");
  chk_exit_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_exit_start |=> !pc_load_out [*4] ##1 (pc_load_out &&
      core_flags_reg[GIE_BIT] && sp_out == $past(sp_out, 5) + 16'h0002))
    // RULE21
    else $error("exit sequence wrong");
  chk_gie_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_entry_start |=> !core_flags_reg[GIE_BIT]) // RULE11
    else $error("entry left global enable set");
  chk_cli_block: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    instr_done_in && op_in.cli |-> !take) // RULE17
    else $error("interrupt taken with disable");
  chk_take_enab: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take |-> s_q.flags[GIE_BIT] && irq_en_in[win]) // RULE7
    else $error("take without enables");
  chk_flag_keep: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_cond_in[0] |=> irq_flag_out[0]) // RULE13
    else $error("flag event lost");
  chk_prio: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && live[0] |=> s_q.sel == 2'h0) // RULE22
    else $error("lower vector not chosen");
  chk_wake_len: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && asleep_in |=> ##8 vec_valid_out) // RULE20
    else $error("wake entry not eight cycles");
  chk_push_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_q.fsm == ST_IDLE && instr_done_in && op_in.push && !io_in.we && !take
    |=> sp_out == $past(sp_out) - 16'h0001) // RULE2
    else $error("push did not decrement by one");
endmodule : cis_core

// ---- verif/cis_mem_model.sv ----
`timescale 1ns/10ps
module cis_mem_model
  import cis_pkg::*;
(
  input wire logic sys_clk_in, // core clock
  input cis_pkg::cis_mem_t mem_in, // stack access
  output logic [7:0] rdata_out // read data
);
  logic [7:0] ram [2048];
  logic [7:0] last;
  // one-cycle read; idle bus shows the inverse so stale data never matches
  always @(posedge sys_clk_in) begin
    if (mem_in.we) begin
      ram[mem_in.addr[10:0]] <= mem_in.wdata;
    end
    if (mem_in.re) begin
      rdata_out <= ram[mem_in.addr[10:0]];
      last <= ram[mem_in.addr[10:0]];
    end else begin
      rdata_out <= ~last;
    end
  end
  initial begin
    last = 8'h00;
    rdata_out = 8'hff;
  end
endmodule : cis_mem_model

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import cis_pkg::*;
  logic sys_clk_in, rst_in, instr_done_in, asleep_in, alu_we_in;
  cis_op_t op_in;
  cis_io_t io_in;
  cis_mem_t mem;
  cis_ptr_cmd_t [2:0] ptr_cmd;
  logic [12:0] pc_in, vec_addr, pc_ret, rst_vec;
  logic [5:0] io_raddr_in;
  logic [6:0] alu_flags_in;
  logic [3:0] irq_cond_in, irq_en_in, irq_flag;
  logic [7:0] mem_rdata, io_rdata, flags;
  logic [15:0] sp;
  logic vec_valid, pc_load, busy;
  logic fuse, lock_app, lock_boot;
  logic [15:0] ptr_val [3];
  logic [15:0] ptr_addr [3];
  int n_errors, checks_done, n_vec, n, v0;

  cis_core uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .instr_done_in(instr_done_in), .op_in(op_in), .asleep_in(asleep_in),
    .pc_in(pc_in), .io_in(io_in), .io_raddr_in(io_raddr_in),
    .alu_flags_in(alu_flags_in), .alu_we_in(alu_we_in),
    .irq_cond_in(irq_cond_in), .irq_en_in(irq_en_in),
    .boot_reset_vector_fuse(fuse), .boot_lock_app_bits(lock_app),
    .boot_lock_boot_bits(lock_boot), .mem_rdata_in(mem_rdata),
    .ptr_cmd_in(ptr_cmd), .io_rdata_out(io_rdata), .sp_out(sp),
    .core_flags_reg(flags), .irq_flag_out(irq_flag), .mem_out(mem),
    .vec_valid_out(vec_valid), .vec_addr_out(vec_addr),
    .pc_load_out(pc_load), .pc_ret_out(pc_ret), .reset_vec_out(rst_vec),
    .busy_out(busy), .ptr_val_out(ptr_val), .ptr_addr_out(ptr_addr));

  cis_mem_model mdl (.sys_clk_in(sys_clk_in), .mem_in(mem),
    .rdata_out(mem_rdata));

  // 50 MHz clock
  always #10 sys_clk_in = ~sys_clk_in;

  // counts vector jumps so silent intervals can be checked
  always @(posedge sys_clk_in) begin
    if (vec_valid === 1'b1) begin
      n_vec++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) io_in <= '{1'b1, a, d};
    @(posedge sys_clk_in) io_in.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk_in) io_raddr_in <= a;
    repeat (2) @(posedge sys_clk_in);
    #1 chk({8'h00, io_rdata}, {8'h00, e});
  endtask : rd

  // one instruction boundary carrying the given class
  task automatic op(input logic [6:0] o);
    @(posedge sys_clk_in) instr_done_in <= 1'b1;
    op_in <= cis_op_t'(o);
    @(posedge sys_clk_in) instr_done_in <= 1'b0;
    op_in <= '0;
  endtask : op

  task automatic pulse(input logic [3:0] c);
    @(posedge sys_clk_in) irq_cond_in <= c;
    @(posedge sys_clk_in) irq_cond_in <= 4'h0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask : pulse

  // edges until vector (sel 0) or return load (sel 1), bounded
  task automatic wt(input bit sel, output int k);
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
      #1;
    end while ((sel ? pc_load : vec_valid) !== 1'b1 && k < 20);
  endtask : wt

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    n_errors++;
    end_of_test();
  end

  initial begin
    sys_clk_in = 0;
    rst_in = 1;
    instr_done_in = 0;
    op_in = '0;
    asleep_in = 0;
    pc_in = 13'h0abc;
    io_in = '0;
    io_raddr_in = 6'h00;
    alu_flags_in = 7'h00;
    alu_we_in = 0;
    irq_cond_in = 4'h0;
    irq_en_in = 4'hf;
    ptr_cmd = '0;
    fuse = 0;
    lock_app = 0;
    lock_boot = 0;
    n_errors = 0;
    checks_done = 0;
    n_vec = 0;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 0;
    @(posedge sys_clk_in);
    #1 chk(sp, 16'h04ff);
    chk({3'h0, rst_vec}, 16'h0000);
    rd(IO_FLAGS, 8'h00);
    rd(6'h3f, 8'h00);
    $display("test reset done");
    // stack moves: push, pop, call, ret
    wr(IO_SPL, 8'h00);
    wr(IO_SPH, 8'h04);
    rd(IO_SPH, 8'h04);
    op(7'h40);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(sp, 16'h03ff);
    op(7'h20);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(sp, 16'h0400);
    op(7'h10);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(sp, 16'h03fe);
    op(7'h08);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(sp, 16'h0400);
    @(posedge sys_clk_in) ptr_cmd[0] <= '{1'b1, 1'b1, 1'b0, 1'b0, 6'h0, 8'h34};
    @(posedge sys_clk_in) ptr_cmd[0] <= '{1'b0, 1'b0, 1'b1, 1'b0, 6'h0, 8'h0};
    @(posedge sys_clk_in) ptr_cmd[0] <= '0;
    @(posedge sys_clk_in);
    #1 chk(ptr_val[0], 16'h3435);
    $display("test stack done");
    // entry: pending while disabled, taken after the instruction past sei
    @(posedge sys_clk_in) alu_flags_in <= 7'h15;
    alu_we_in <= 1'b1;
    @(posedge sys_clk_in) alu_we_in <= 1'b0;
    pulse(4'h1);
    chk({12'h0, irq_flag}, 16'h0001);
    op(7'h02);
    op(7'h00);
    wt(0, n);
    chk(n[15:0], 16'h0004);
    chk({3'h0, vec_addr}, 16'h0002);
    chk({8'h0, flags}, 16'h0015);
    chk({12'h0, irq_flag}, 16'h0000);
    chk(sp, 16'h03fe);
    $display("test entry done");
    // return, then one instruction before the next pending source
    pulse(4'h6);
    pulse(4'h8);
    chk({12'h0, irq_flag}, 16'h0006);
    op(7'h04);
    wt(1, n);
    chk(n[15:0], 16'h0004);
    chk({3'h0, pc_ret}, 16'h0abc);
    chk(sp, 16'h0400);
    chk({8'h0, flags}, 16'h0095);
    v0 = n_vec;
    repeat (4) @(posedge sys_clk_in);
    chk(n_vec[15:0], v0[15:0]);
    op(7'h00);
    wt(0, n);
    chk({3'h0, vec_addr}, 16'h0004);
    chk({12'h0, irq_flag}, 16'h0004);
    wr(IO_IFLAG, 8'h04);
    #1 chk({12'h0, irq_flag}, 16'h0000);
    op(7'h04);
    wt(1, n);
    $display("test return done");
    // disable in the same cycle as a live request
    pulse(4'h1);
    v0 = n_vec;
    op(7'h01);
    repeat (8) @(posedge sys_clk_in);
    chk(n_vec[15:0], v0[15:0]);
    #1 chk({12'h0, irq_flag}, 16'h0001);
    // relocated vectors
    wr(IO_CTRL, 8'h02);
    wr(IO_FLAGS, 8'h80);
    op(7'h00);
    wt(0, n);
    chk({3'h0, vec_addr}, 16'h1c02);
    op(7'h04);
    wt(1, n);
    $display("test disable and relocate done");
    // lock bit blocks a pending source while in the application section
    @(posedge sys_clk_in) lock_app <= 1'b1;
    pulse(4'h1);
    v0 = n_vec;
    op(7'h00);
    repeat (8) @(posedge sys_clk_in);
    chk(n_vec[15:0], v0[15:0]);
    // wake from sleep adds four cycles ahead of the entry
    @(posedge sys_clk_in) lock_app <= 1'b0;
    asleep_in <= 1'b1;
    wt(0, n);
    chk(n[15:0], 16'h0009);
    chk({3'h0, vec_addr}, 16'h1c02);
    @(posedge sys_clk_in) asleep_in <= 1'b0;
    op(7'h04);
    wt(1, n);
    // fuse moves the reset vector to the boot section
    @(posedge sys_clk_in) fuse <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 chk({3'h0, rst_vec}, 16'h1c00);
    $display("test lock, wake and fuse done");
    end_of_test();
  end
endmodule : tb_top
